// *** design/clk_gate_pkg.sv ***
// Package: register map, field layout and state types of the clock gate and oscillator control
package clk_gate_pkg;
	// Register byte addresses
	localparam logic [31:0] ADDR_COPROC_CLK  = 32'h400e_0408;
	localparam logic [31:0] ADDR_PCLK_EN     = 32'h400e_0410;
	localparam logic [31:0] ADDR_PCLK_DIS    = 32'h400e_0414;
	localparam logic [31:0] ADDR_PCLK_STAT   = 32'h400e_0418;
	localparam logic [31:0] ADDR_MAIN_OSC    = 32'h400e_0420;
	localparam logic [31:0] ADDR_FREQ_MEAS   = 32'h400e_0424;
	localparam logic [31:0] ADDR_WR_PROTECT  = 32'h400e_04e4;
	// Implemented peripheral identifiers: bits 8 to 31 without bit 30
	localparam logic [31:0] PERIPH_IMPL_MASK = 32'hbfff_ff00;
	// Coprocessor clock control and write protection fields
	localparam int          CP_CORE_BIT      = 16;
	localparam int          CP_BUSM_BIT      = 17;
	localparam int          WP_ON_BIT        = 0;
	// Main oscillator control fields
	localparam int          MOR_XT_EN_BIT    = 0;
	localparam int          MOR_XT_BY_BIT    = 1;
	localparam int          MOR_WAIT_BIT     = 2;
	localparam int          MOR_RC_EN_BIT    = 3;
	localparam int          MOR_RCF_LSB      = 4;
	localparam int          MOR_XTST_LSB     = 8;
	localparam int          MOR_KEY_LSB      = 16;
	localparam int          MOR_SEL_BIT      = 24;
	localparam int          MOR_CFD_BIT      = 25;
	localparam int          MOR_XT32_BIT     = 26;
	localparam logic [7:0]  MOR_KEY_PASS     = 8'h37;
	localparam logic [31:0] MOR_RESET        = 32'h0000_0008;
	// Frequency measurement fields
	localparam int          MCF_RDY_BIT      = 16;
	localparam int          MCF_RESTART_BIT  = 20;
	// RC frequency codes
	localparam logic [2:0]  RCF_4MHZ         = 3'h0;
	localparam logic [2:0]  RCF_8MHZ         = 3'h1;
	localparam logic [2:0]  RCF_12MHZ        = 3'h2;
	// Timing in slow clock cycles
	localparam int          XT_STARTUP_SHIFT = 3;
	localparam logic [3:0]  RC_STARTUP_SLOW  = 4'h8;
	localparam logic [4:0]  MEAS_SLOW_LAST   = 5'h0f;

	typedef enum logic [1:0] {MEAS_IDLE, MEAS_ALIGN, MEAS_COUNT} meas_state_t;

	typedef struct packed {
		logic       xt_en;
		logic       xt_bypass;
		logic       rc_en;
		logic [2:0] rc_freq;
		logic [7:0] xt_startup;
		logic       main_sel;
		logic       cfd_on;
		logic       slow_rc_on;
		logic       slow_xt_mon;
	} osc_ctrl_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [2:0]  slow_sync;
		logic [2:0]  main_sync;
		logic [31:0] periph_en;
		logic        cp_core;
		logic        cp_busm;
		logic        wp_on;
		osc_ctrl_t   osc;
		logic        wait_pulse;
		logic        xt_rdy;
		logic [10:0] xt_cnt;
		logic        rc_rdy;
		logic [3:0]  rc_cnt;
		meas_state_t meas;
		logic        meas_done;
		logic        freq_rdy;
		logic [4:0]  meas_per;
		logic [15:0] meas_cnt;
		logic [15:0] main_freq;
	} gate_state_t;
endpackage : clk_gate_pkg

// *** design/periph_clock_gate_main_osc_ctrl.sv ***
// Peripheral clock gating, coprocessor clock status and main oscillator control over APB
`timescale 1ns/1ps
// Notes on behaviour
// - Coprocessor core clock status is 0 after reset, 1 only while core clocks run.
// - Coprocessor bus-master clock status is 0 after reset, 1 only while enabled.
// - Writing 1 to an enable bit turns on that peripheral clock; 0 does nothing.
// - Writing 1 to a disable bit turns off that peripheral clock; 0 does nothing.
// - Peripheral status register shows 1 for each enabled clock, 0 otherwise.
// - Protected registers ignore writes while write protection is on.
// - Bits of unimplemented peripheral identifiers have no effect.
// - Oscillator register writes need key 0x37; key field reads back as zero.
// - Crystal ready rises after start-up field times 8 slow clock cycles.
// - Crystal bypass sets crystal ready at once.
// - Clearing both crystal enable and bypass clears crystal ready.
// - Writing 1 to the wait command requests wait mode; 0 does nothing.
// - RC ready rises after RC start-up time; clearing enable stops the RC.
// - RC frequency code 0 is 4 MHz, 1 is 8 MHz, 2 is 12 MHz; resets to 4.
// - Main source select picks RC when 0, crystal when 1.
// - Failure detector enable also switches on the slow RC oscillator.
// - Slow crystal monitor bit turns 32.768 kHz monitoring on or off.
// - Frequency count holds main clock cycles within 16 slow clock periods.
// - Measure ready is 1 only with the source running and a valid count.
// - Writing 1 to measure restart starts a new count; ready falls meanwhile.
module periph_clock_gate_main_osc_ctrl (
	// Clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// APB slave
	input  wire logic [31:0]             paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Clock pins sampled for start-up timing and measurement
	input  wire logic                    slow_clk_in,
	input  wire logic                    main_clk_in,
	// Gated clock enables
	output logic      [31:0]             periph_clk_en,
	output logic                         coproc_core_clk_on,
	output logic                         coproc_busmaster_clk_on,
	// Oscillator controls and status
	output clk_gate_pkg::osc_ctrl_t      osc_ctrl,
	output logic                         crystal_ready_flag,
	output logic                         rc_ready_flag,
	output logic                         freq_count_ready,
	output logic                         wait_command
);
	clk_gate_pkg::gate_state_t st_ff;
	clk_gate_pkg::gate_state_t nxt_st;

	logic        setup_ph;
	logic        wr_done;
	logic        wr_ok;
	logic        mapped;
	logic        key_ok;
	logic        slow_tick;
	logic        main_tick;
	logic        osc_ok;
	logic [31:0] rd_mux;
	logic [31:0] wdata_impl;

	always_comb begin
		nxt_st = st_ff;
		// Pin synchronisers; only the second and third stages feed logic
		nxt_st.slow_sync = {st_ff.slow_sync[1:0], slow_clk_in};
		nxt_st.main_sync = {st_ff.main_sync[1:0], main_clk_in};
		// Main clock is sampled at pclk, so counts saturate near half that rate
		slow_tick = st_ff.slow_sync[1] & ~st_ff.slow_sync[2];
		main_tick = st_ff.main_sync[1] & ~st_ff.main_sync[2];

		mapped = (paddr == clk_gate_pkg::ADDR_COPROC_CLK) ||
			(paddr == clk_gate_pkg::ADDR_PCLK_EN) ||
			(paddr == clk_gate_pkg::ADDR_PCLK_DIS) ||
			(paddr == clk_gate_pkg::ADDR_PCLK_STAT) ||
			(paddr == clk_gate_pkg::ADDR_MAIN_OSC) ||
			(paddr == clk_gate_pkg::ADDR_FREQ_MEAS) ||
			(paddr == clk_gate_pkg::ADDR_WR_PROTECT);
		setup_ph = psel & ~penable;
		wr_done = psel & penable & st_ff.pready & pwrite & ~st_ff.pslverr;
		wr_ok = wr_done & ~st_ff.wp_on;
		key_ok = pwdata[clk_gate_pkg::MOR_KEY_LSB +: 8] == clk_gate_pkg::MOR_KEY_PASS;
		wdata_impl = pwdata & clk_gate_pkg::PERIPH_IMPL_MASK;

		// Read mux; key and wait command always read as zero
		rd_mux = '0;
		case (paddr)
			clk_gate_pkg::ADDR_COPROC_CLK: begin
				rd_mux[clk_gate_pkg::CP_CORE_BIT] = st_ff.cp_core;
				rd_mux[clk_gate_pkg::CP_BUSM_BIT] = st_ff.cp_busm;
			end
			clk_gate_pkg::ADDR_PCLK_STAT: begin
				rd_mux = st_ff.periph_en;
			end
			clk_gate_pkg::ADDR_MAIN_OSC: begin
				rd_mux[clk_gate_pkg::MOR_XT_EN_BIT] = st_ff.osc.xt_en;
				rd_mux[clk_gate_pkg::MOR_XT_BY_BIT] = st_ff.osc.xt_bypass;
				rd_mux[clk_gate_pkg::MOR_RC_EN_BIT] = st_ff.osc.rc_en;
				rd_mux[clk_gate_pkg::MOR_RCF_LSB +: 3] = st_ff.osc.rc_freq;
				rd_mux[clk_gate_pkg::MOR_XTST_LSB +: 8] = st_ff.osc.xt_startup;
				rd_mux[clk_gate_pkg::MOR_SEL_BIT] = st_ff.osc.main_sel;
				rd_mux[clk_gate_pkg::MOR_CFD_BIT] = st_ff.osc.cfd_on;
				rd_mux[clk_gate_pkg::MOR_XT32_BIT] = st_ff.osc.slow_xt_mon;
			end
			clk_gate_pkg::ADDR_FREQ_MEAS: begin
				rd_mux[15:0] = st_ff.main_freq;
				rd_mux[clk_gate_pkg::MCF_RDY_BIT] = st_ff.freq_rdy;
			end
			clk_gate_pkg::ADDR_WR_PROTECT: begin
				rd_mux[clk_gate_pkg::WP_ON_BIT] = st_ff.wp_on;
			end
			default: begin
				rd_mux = '0;
			end
		endcase

		// Zero-wait APB: answer is ready in the first access cycle
		nxt_st.pready = setup_ph;
		nxt_st.pslverr = setup_ph & ~mapped;
		if (setup_ph) begin
			nxt_st.prdata = pwrite ? '0 : rd_mux;
		end

		nxt_st.wait_pulse = 1'b0;

		// Peripheral clock enable and disable
		if (wr_ok && paddr == clk_gate_pkg::ADDR_PCLK_EN) begin
			nxt_st.periph_en = st_ff.periph_en | wdata_impl;
		end
		if (wr_ok && paddr == clk_gate_pkg::ADDR_PCLK_DIS) begin
			nxt_st.periph_en = st_ff.periph_en & ~wdata_impl;
		end

		if (wr_ok && paddr == clk_gate_pkg::ADDR_COPROC_CLK) begin
			nxt_st.cp_core = pwdata[clk_gate_pkg::CP_CORE_BIT];
			nxt_st.cp_busm = pwdata[clk_gate_pkg::CP_BUSM_BIT];
		end

		// Protection register itself stays writable so software can unlock
		if (wr_done && paddr == clk_gate_pkg::ADDR_WR_PROTECT) begin
			nxt_st.wp_on = pwdata[clk_gate_pkg::WP_ON_BIT];
		end

		// Crystal oscillator start-up
		if (st_ff.osc.xt_bypass) begin
			nxt_st.xt_rdy = 1'b1;
		end else if (!st_ff.osc.xt_en) begin
			nxt_st.xt_rdy = 1'b0;
		end else if (!st_ff.xt_rdy && slow_tick) begin
			if (st_ff.xt_cnt == '0) begin
				nxt_st.xt_rdy = 1'b1;
			end else begin
				nxt_st.xt_cnt = st_ff.xt_cnt - 11'h001;
			end
		end

		// RC oscillator start-up
		if (!st_ff.osc.rc_en) begin
			nxt_st.rc_rdy = 1'b0;
			nxt_st.rc_cnt = clk_gate_pkg::RC_STARTUP_SLOW;
		end else if (!st_ff.rc_rdy && slow_tick) begin
			if (st_ff.rc_cnt == '0) begin
				nxt_st.rc_rdy = 1'b1;
			end else begin
				nxt_st.rc_cnt = st_ff.rc_cnt - 4'h1;
			end
		end

		// Main oscillator control write, only with the right key
		if (wr_ok && paddr == clk_gate_pkg::ADDR_MAIN_OSC && key_ok) begin
			nxt_st.osc.xt_en = pwdata[clk_gate_pkg::MOR_XT_EN_BIT];
			nxt_st.osc.xt_bypass = pwdata[clk_gate_pkg::MOR_XT_BY_BIT];
			nxt_st.osc.rc_en = pwdata[clk_gate_pkg::MOR_RC_EN_BIT];
			nxt_st.osc.rc_freq = pwdata[clk_gate_pkg::MOR_RCF_LSB +: 3];
			nxt_st.osc.xt_startup = pwdata[clk_gate_pkg::MOR_XTST_LSB +: 8];
			nxt_st.osc.main_sel = pwdata[clk_gate_pkg::MOR_SEL_BIT];
			nxt_st.osc.cfd_on = pwdata[clk_gate_pkg::MOR_CFD_BIT];
			nxt_st.osc.slow_rc_on = pwdata[clk_gate_pkg::MOR_CFD_BIT];
			nxt_st.osc.slow_xt_mon = pwdata[clk_gate_pkg::MOR_XT32_BIT];
			nxt_st.wait_pulse = pwdata[clk_gate_pkg::MOR_WAIT_BIT];
			// Relies on software keeping ready low before enabling the crystal
			if (pwdata[clk_gate_pkg::MOR_XT_EN_BIT] && !st_ff.osc.xt_en) begin
				nxt_st.xt_cnt = 11'(pwdata[clk_gate_pkg::MOR_XTST_LSB +: 8]) <<
					clk_gate_pkg::XT_STARTUP_SHIFT;
			end
		end

		// Frequency measurement of the selected main source
		osc_ok = st_ff.osc.main_sel ? st_ff.xt_rdy : st_ff.rc_rdy;
		if (!osc_ok) begin
			nxt_st.meas = clk_gate_pkg::MEAS_IDLE;
			nxt_st.freq_rdy = 1'b0;
			nxt_st.meas_done = 1'b0;
		end else begin
			case (st_ff.meas)
				clk_gate_pkg::MEAS_IDLE: begin
					if (!st_ff.meas_done) begin
						nxt_st.meas = clk_gate_pkg::MEAS_ALIGN;
					end
				end
				clk_gate_pkg::MEAS_ALIGN: begin
					// Start on a slow edge so the window is a whole number of periods
					if (slow_tick) begin
						nxt_st.meas = clk_gate_pkg::MEAS_COUNT;
						nxt_st.meas_per = '0;
						nxt_st.meas_cnt = '0;
					end
				end
				clk_gate_pkg::MEAS_COUNT: begin
					if (main_tick && st_ff.meas_cnt != 16'hffff) begin
						nxt_st.meas_cnt = st_ff.meas_cnt + 16'h0001;
					end
					if (slow_tick) begin
						nxt_st.meas_per = st_ff.meas_per + 5'h01;
						if (st_ff.meas_per == clk_gate_pkg::MEAS_SLOW_LAST) begin
							nxt_st.main_freq = nxt_st.meas_cnt;
							nxt_st.freq_rdy = 1'b1;
							nxt_st.meas_done = 1'b1;
							nxt_st.meas = clk_gate_pkg::MEAS_IDLE;
						end
					end
				end
				default: begin
					nxt_st.meas = clk_gate_pkg::MEAS_IDLE;
				end
			endcase
		end
		if (wr_ok && paddr == clk_gate_pkg::ADDR_FREQ_MEAS &&
				pwdata[clk_gate_pkg::MCF_RESTART_BIT]) begin
			nxt_st.freq_rdy = 1'b0;
			nxt_st.meas_done = 1'b0;
			nxt_st.meas = clk_gate_pkg::MEAS_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.osc.rc_en <= clk_gate_pkg::MOR_RESET[clk_gate_pkg::MOR_RC_EN_BIT];
			st_ff.osc.rc_freq <= clk_gate_pkg::RCF_4MHZ;
			st_ff.rc_cnt <= clk_gate_pkg::RC_STARTUP_SLOW;
			st_ff.meas <= clk_gate_pkg::MEAS_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign periph_clk_en = st_ff.periph_en;
	assign coproc_core_clk_on = st_ff.cp_core;
	assign coproc_busmaster_clk_on = st_ff.cp_busm;
	assign osc_ctrl = st_ff.osc;
	assign crystal_ready_flag = st_ff.xt_rdy;
	assign rc_ready_flag = st_ff.rc_rdy;
	assign freq_count_ready = st_ff.freq_rdy;
	assign wait_command = st_ff.wait_pulse;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	wp_block_a: assert property (
		(wr_done && st_ff.wp_on && paddr != clk_gate_pkg::ADDR_WR_PROTECT) |=>
			$stable(periph_clk_en) && $stable(osc_ctrl) && $stable(coproc_core_clk_on))
		else $error("write passed while protected");
	pce_set_a: assert property (
		(wr_ok && paddr == clk_gate_pkg::ADDR_PCLK_EN) |=>
			periph_clk_en == ($past(periph_clk_en) |
				($past(pwdata) & clk_gate_pkg::PERIPH_IMPL_MASK)))
		else $error("enable write did not set clocks");
	pcd_clr_a: assert property (
		(wr_ok && paddr == clk_gate_pkg::ADDR_PCLK_DIS) |=>
			periph_clk_en == ($past(periph_clk_en) &
				~($past(pwdata) & clk_gate_pkg::PERIPH_IMPL_MASK)))
		else $error("disable write did not clear clocks");
	unimpl_zero_a: assert property (
		(periph_clk_en & ~clk_gate_pkg::PERIPH_IMPL_MASK) == '0)
		else $error("unimplemented clock bit set");
	stat_read_a: assert property (
		(setup_ph && !pwrite && paddr == clk_gate_pkg::ADDR_PCLK_STAT) |=>
			prdata == $past(periph_clk_en) && pready)
		else $error("status read mismatch");
	bad_key_a: assert property (
		(wr_done && paddr == clk_gate_pkg::ADDR_MAIN_OSC && !key_ok) |=>
			$stable(osc_ctrl) && !wait_command)
		else $error("oscillator write without key took effect");
	key_read_a: assert property (
		(setup_ph && !pwrite && paddr == clk_gate_pkg::ADDR_MAIN_OSC) |=>
			prdata[clk_gate_pkg::MOR_KEY_LSB +: 8] == 8'h00)
		else $error("key field read nonzero");
	bypass_rdy_a: assert property (
		osc_ctrl.xt_bypass |=> crystal_ready_flag)
		else $error("bypass did not set crystal ready");
	xt_off_a: assert property (
		(!osc_ctrl.xt_en && !osc_ctrl.xt_bypass) |=> !crystal_ready_flag)
		else $error("crystal ready stayed without enable");
	xt_early_a: assert property (
		(!osc_ctrl.xt_bypass && !crystal_ready_flag && st_ff.xt_cnt != '0) |=>
			!crystal_ready_flag)
		else $error("crystal ready before start-up count");
	rc_off_a: assert property (
		!osc_ctrl.rc_en |=> !rc_ready_flag)
		else $error("rc ready without enable");
	cfd_rc_a: assert property (
		osc_ctrl.cfd_on == osc_ctrl.slow_rc_on)
		else $error("slow rc not tied to failure detector");
	restart_a: assert property (
		(wr_ok && paddr == clk_gate_pkg::ADDR_FREQ_MEAS &&
			pwdata[clk_gate_pkg::MCF_RESTART_BIT]) |=> !freq_count_ready ##1 !freq_count_ready)
		else $error("measure ready did not drop on restart");
	meas_src_a: assert property (
		freq_count_ready |-> $past(osc_ctrl.main_sel ? crystal_ready_flag : rc_ready_flag))
		else $error("measure ready with source stopped");

	xt_ready_c: cover property ($rose(crystal_ready_flag) && osc_ctrl.xt_en);
	meas_ready_c: cover property ($rose(freq_count_ready));
	pce_write_c: cover property (wr_ok && paddr == clk_gate_pkg::ADDR_PCLK_EN ##1
		periph_clk_en != '0);
	wait_cmd_c: cover property (wait_command);
endmodule : periph_clock_gate_main_osc_ctrl

// *** testbench/osc_source_model.sv ***
// Clock source model driving the slow and main oscillator pins of the block
`timescale 1ns/1ps
module osc_source_model #(
	parameter time SLOW_HALF = 200,
	parameter time MAIN_HALF = 50
) (
	// Oscillator pins
	output logic slow_clk,
	output logic main_clk
);
	// Start off the bus clock edges; main stays well under half the bus rate
	initial begin
		slow_clk = 1'b0;
		#7;
		forever #(SLOW_HALF) slow_clk = ~slow_clk;
	end
	initial begin
		main_clk = 1'b0;
		#7;
		forever #(MAIN_HALF) main_clk = ~main_clk;
	end
endmodule : osc_source_model

// *** testbench/tb_periph_clock_gate_main_osc_ctrl.sv ***
// Self-checking bench for the peripheral clock gate and oscillator control
`timescale 1ns/1ps
module tb_periph_clock_gate_main_osc_ctrl;
	logic                    pclk;
	logic                    presetn;
	logic [31:0]             paddr;
	logic                    psel;
	logic                    penable;
	logic                    pwrite;
	logic [31:0]             pwdata;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	logic                    slow_clk;
	logic                    main_clk;
	logic [31:0]             pen;
	logic                    cp_core;
	logic                    cp_busm;
	clk_gate_pkg::osc_ctrl_t osc;
	logic                    xt_rdy;
	logic                    rc_rdy;
	logic                    f_rdy;
	logic                    wait_cmd;
	logic [31:0]             rd;
	logic                    err;
	int                      n_fail;
	int                      comparisons;
	int                      n_wait;
	localparam logic [31:0]  KEY = 32'h0037_0000;
	localparam int           EXP_F = 16 * 400 / 100;
	logic [31:0]             osc_vals [4] = '{32'h0700_0018, 32'h0000_0028,
		32'h0200_0008, 32'h0000_0008};

	osc_source_model src (.slow_clk(slow_clk), .main_clk(main_clk));

	periph_clock_gate_main_osc_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .slow_clk_in(slow_clk), .main_clk_in(main_clk),
		.periph_clk_en(pen), .coproc_core_clk_on(cp_core),
		.coproc_busmaster_clk_on(cp_busm), .osc_ctrl(osc), .crystal_ready_flag(xt_rdy),
		.rc_ready_flag(rc_rdy), .freq_count_ready(f_rdy), .wait_command(wait_cmd));

	initial pclk = 1'b0;
	always #10 pclk = ~pclk;

	// Wait pulses are one cycle wide, so they are counted rather than polled
	always @(posedge pclk) if (wait_cmd === 1'b1) n_wait <= n_wait + 1;

	task summarize();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_fail++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask : rdc

	// Flag 0 crystal ready, 1 RC ready, 2 measure ready
	task wait_on(input int sel, input int limit);
		int i;
		for (i = 0; i < limit; i++) begin
			@(posedge pclk);
			if ((sel == 0 ? xt_rdy : sel == 1 ? rc_rdy : f_rdy) === 1'b1) break;
		end
		if (i == limit) begin
			n_fail++;
			summarize();
		end
	endtask : wait_on

	initial begin
		presetn = 1'b0;
		paddr = 32'h0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
		n_fail = 0;
		comparisons = 0;
		n_wait = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk("cp_core", cp_core, 32'h0);
		chk("cp_busm", cp_busm, 32'h0);
		rdc("pclk_stat", clk_gate_pkg::ADDR_PCLK_STAT, 32'h0);
		rdc("osc_reset", clk_gate_pkg::ADDR_MAIN_OSC, clk_gate_pkg::MOR_RESET);
		// Writes under protection must leave everything as it was
		wr(clk_gate_pkg::ADDR_WR_PROTECT, 32'h1);
		wr(clk_gate_pkg::ADDR_PCLK_EN, 32'hffff_ffff);
		wr(clk_gate_pkg::ADDR_MAIN_OSC, KEY | 32'h0100_0008);
		rdc("prot_stat", clk_gate_pkg::ADDR_PCLK_STAT, 32'h0);
		rdc("prot_osc", clk_gate_pkg::ADDR_MAIN_OSC, clk_gate_pkg::MOR_RESET);
		wr(clk_gate_pkg::ADDR_WR_PROTECT, 32'h0);
		wr(clk_gate_pkg::ADDR_PCLK_EN, 32'hffff_ffff);
		#1;
		chk("pen_on", pen, clk_gate_pkg::PERIPH_IMPL_MASK);
		wr(clk_gate_pkg::ADDR_PCLK_DIS, 32'h8000_01ff);
		#1;
		chk("pen_off", pen, 32'h3fff_fe00);
		wr(clk_gate_pkg::ADDR_PCLK_EN, 32'h0);
		wr(clk_gate_pkg::ADDR_PCLK_DIS, 32'h0);
		wr(clk_gate_pkg::ADDR_PCLK_STAT, 32'h0);
		rdc("pclk_stat", clk_gate_pkg::ADDR_PCLK_STAT, 32'h3fff_fe00);
		wr(clk_gate_pkg::ADDR_COPROC_CLK, 32'h0003_0000);
		#1;
		chk("cp_core", cp_core, 32'h1);
		chk("cp_busm", cp_busm, 32'h1);
		wr(clk_gate_pkg::ADDR_MAIN_OSC, 32'h0036_0001);
		rdc("bad_key", clk_gate_pkg::ADDR_MAIN_OSC, clk_gate_pkg::MOR_RESET);
		wait_on(1, 1000);
		chk("rc_rdy", rc_rdy, 32'h1);
		// RC code changes only with RC ready, never together with RC enable
		foreach (osc_vals[k]) begin
			wr(clk_gate_pkg::ADDR_MAIN_OSC, KEY | osc_vals[k]);
			rdc("osc", clk_gate_pkg::ADDR_MAIN_OSC, osc_vals[k]);
			chk("main_sel", osc.main_sel, osc_vals[k][24]);
			chk("cfd", osc.slow_rc_on, osc_vals[k][25]);
			chk("xt_mon", osc.slow_xt_mon, osc_vals[k][26]);
		end
		chk("xt_idle", xt_rdy, 32'h0);
		wr(clk_gate_pkg::ADDR_MAIN_OSC, KEY | 32'h0000_0109);
		repeat (140) @(posedge pclk);
		chk("xt_early", xt_rdy, 32'h0);
		wait_on(0, 400);
		chk("xt_rdy", xt_rdy, 32'h1);
		wr(clk_gate_pkg::ADDR_MAIN_OSC, KEY | 32'h0000_0008);
		repeat (2) @(posedge pclk);
		chk("xt_clear", xt_rdy, 32'h0);
		wr(clk_gate_pkg::ADDR_MAIN_OSC, KEY | 32'h0000_000a);
		repeat (2) @(posedge pclk);
		chk("bypass", xt_rdy, 32'h1);
		wr(clk_gate_pkg::ADDR_MAIN_OSC, KEY | 32'h0000_000c);
		rdc("wait_wo", clk_gate_pkg::ADDR_MAIN_OSC, 32'h0000_0008);
		chk("wait_cnt", n_wait, 32'h1);
		chk("xt_clear", xt_rdy, 32'h0);
		wait_on(2, 2000);
		xfer(1'b0, clk_gate_pkg::ADDR_FREQ_MEAS, 32'h0);
		chk("f_rdy", rd[16], 32'h1);
		chk("f_cnt", rd[15:0] >= EXP_F - 1 && rd[15:0] <= EXP_F + 1, 32'h1);
		wr(clk_gate_pkg::ADDR_FREQ_MEAS, 32'h0010_0000);
		#1;
		chk("restart", f_rdy, 32'h0);
		wait_on(2, 2000);
		xfer(1'b0, clk_gate_pkg::ADDR_FREQ_MEAS, 32'h0);
		chk("f_cnt2", rd[15:0] >= EXP_F - 1 && rd[15:0] <= EXP_F + 1, 32'h1);
		// Dropping the RC source must clear its ready flag and then the measure flag
		wr(clk_gate_pkg::ADDR_MAIN_OSC, KEY | 32'h0000_0000);
		repeat (3) @(posedge pclk);
		chk("rc_off", rc_rdy, 32'h0);
		chk("f_off", f_rdy, 32'h0);
		xfer(1'b0, 32'h400e_0500, 32'h0);
		chk("unmapped_err", err, 32'h1);
		chk("unmapped_rd", rd, 32'h0);
		summarize();
	end
endmodule : tb_periph_clock_gate_main_osc_ctrl
